// [sync_measure_params.svh]
`ifndef SYNC_MEASURE_PARAMS_SVH
`define SYNC_MEASURE_PARAMS_SVH
// Overview of operation
// - filter enabled: a masking window opens at each horizontal sync leading edge that falls outside an open window
// - window length is twice the 8-bit width setting in reference ticks
// - filter disabled: width setting has no effect, no window opens
// - vertical leading edge is delayed or advanced by a signed pixel count
// - field output is shifted by the same offset as vertical sync
// - alignment is ignored while either sync passthrough is active
// - horizontal passthrough drives raw horizontal sync to the output
// - vertical passthrough drives raw vertical sync to the output
// - horizontal invert flips the output only during horizontal passthrough
// - vertical invert flips the output only during vertical passthrough
// - lines per frame counted, 12 bits over two read-only bytes
// - pseudo-sync detect flag sits in bit 6 of the upper line byte
// - scan type bit reads 1 progressive, 0 interlaced, lock independent
// - reference ticks per line, longest line of the frame, 12 bits
// - counters use internal 6.5 MHz or external reference up to 27 MHz
// - measurement runs whether or not the pixel clock loop is locked
// - horizontal sync width in reference ticks, 8 bits read-only
// - vertical sync width in lines, 5 bits read-only
// - 27 MHz, 480p input reads 858 clocks, 525 lines, width 63
`define IDX_MASK_WIDTH 8'h34
`define IDX_ALIGN 8'h35
`define IDX_PASS 8'h36
`define IDX_LINES_LO 8'h37
`define IDX_LINES_HI 8'h38
`define IDX_CLOCKS_LO 8'h39
`define IDX_CLOCKS_HI 8'h3A
`define IDX_HS_WIDTH 8'h3B
`define IDX_VS_WIDTH 8'h3C
`define IDX_CTRL 8'h50
`define RST_MASK_WIDTH 8'h03
`define RST_ALIGN 8'h10
`define RST_PASS 4'h0
`define RST_CTRL 2'h0
`define BIT_HORIZONTAL_RAW_PASSTHROUGH 0
`define BIT_VERTICAL_RAW_PASSTHROUGH 1
`define BIT_HORIZONTAL_OUTPUT_INVERT 2
`define BIT_VERTICAL_OUTPUT_INVERT 3
`define BIT_FILTER_EN 0
`define BIT_EXT_REF 1
`define CLK_KHZ 125000
`define REF_INT_KHZ 6500
`define REF_INT_DIV (`CLK_KHZ / `REF_INT_KHZ)
`endif

// [sync_measure_pkg.sv]
package sync_measure_pkg;
  typedef struct packed {
    logic [11:0] lines;
    logic [11:0] clocks;
    logic [7:0] hsWidth;
    logic [4:0] vsWidth;
    logic progressive;
    logic pseudoSync;
  } status_s;
  typedef enum logic [2:0] {
    AL_IDLE = 3'b001,
    AL_WAIT = 3'b010,
    AL_COUNT = 3'b100
  } align_e;
endpackage

// [sync_measure_and_align.sv]
`timescale 1ns/1ps
`include "sync_measure_params.svh"
module sync_measure_and_align #(
  parameter int PIX_W = 13
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hsyncIn,
  input wire logic vsyncIn,
  input wire logic pixelStrobe,
  input wire logic externalReferenceInput,
  output logic hsyncOut,
  output logic vsyncOut,
  output logic fieldOut,
  output logic hsyncFiltered
);

  if (PIX_W < 9)
  begin : gBadWidth
    $error("PIX_W must be at least 9");
  end

  // ****************************************
  // register bus
  // ****************************************
  function automatic logic isIdx(input logic [11:0] a, input logic [7:0] idx);
    isIdx = (a == {2'b00, idx, 2'b00});
  endfunction

  logic [7:0] maskWidth_reg;
  logic [7:0] alignOffset_reg;
  logic [3:0] pass_reg;
  logic [1:0] ctrl_reg;
  logic [31:0] prdata_reg;
  sync_measure_pkg::status_s stat_reg;
  sync_measure_pkg::status_s stat_next;

  wire access = psel & penable;
  wire wrEn = access & pwrite;
  wire hitMask = isIdx(paddr, `IDX_MASK_WIDTH);
  wire hitAlign = isIdx(paddr, `IDX_ALIGN);
  wire hitPass = isIdx(paddr, `IDX_PASS);
  wire hitLinesLo = isIdx(paddr, `IDX_LINES_LO);
  wire hitLinesHi = isIdx(paddr, `IDX_LINES_HI);
  wire hitClkLo = isIdx(paddr, `IDX_CLOCKS_LO);
  wire hitClkHi = isIdx(paddr, `IDX_CLOCKS_HI);
  wire hitHsw = isIdx(paddr, `IDX_HS_WIDTH);
  wire hitVsw = isIdx(paddr, `IDX_VS_WIDTH);
  wire hitCtrl = isIdx(paddr, `IDX_CTRL);
  wire mapped = hitMask | hitAlign | hitPass | hitLinesLo | hitLinesHi | hitClkLo
    | hitClkHi | hitHsw | hitVsw | hitCtrl;

  wire [7:0] rdByte =
    hitMask ? maskWidth_reg :
    hitAlign ? alignOffset_reg :
    hitPass ? {4'h0, pass_reg} :
    hitLinesLo ? stat_reg.lines[7:0] :
    hitLinesHi ? {1'b0, stat_reg.pseudoSync, stat_reg.progressive, 1'b0,
                  stat_reg.lines[11:8]} :
    hitClkLo ? stat_reg.clocks[7:0] :
    hitClkHi ? {4'h0, stat_reg.clocks[11:8]} :
    hitHsw ? stat_reg.hsWidth :
    hitVsw ? {3'h0, stat_reg.vsWidth} :
    hitCtrl ? {6'h00, ctrl_reg} : 8'h00;

  // read data is captured in the setup cycle so no wait state is needed
  wire [31:0] prdata_next = (psel & ~penable) ? {24'h000000, rdByte} : prdata_reg;

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      maskWidth_reg <= `RST_MASK_WIDTH;
      alignOffset_reg <= `RST_ALIGN;
      pass_reg <= `RST_PASS;
      ctrl_reg <= `RST_CTRL;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      if (wrEn & hitMask)
        maskWidth_reg <= pwdata[7:0];
      if (wrEn & hitAlign)
        alignOffset_reg <= pwdata[7:0];
      if (wrEn & hitPass)
        pass_reg <= pwdata[3:0];
      if (wrEn & hitCtrl)
        ctrl_reg <= pwdata[1:0];
      prdata_reg <= prdata_next;
    end
  end

  wire hsBypass = pass_reg[`BIT_HORIZONTAL_RAW_PASSTHROUGH];
  wire vsBypass = pass_reg[`BIT_VERTICAL_RAW_PASSTHROUGH];
  wire anyBypass = hsBypass | vsBypass;
  wire filterEn = ctrl_reg[`BIT_FILTER_EN];

  // ****************************************
  // input edges and reference tick
  // ****************************************
  logic hsPrev_reg;
  logic vsPrev_reg;
  logic extPrev_reg;
  logic [7:0] divCnt_reg;

  wire hsLead = hsyncIn & ~hsPrev_reg;
  wire hsTrail = ~hsyncIn & hsPrev_reg;
  wire vsLead = vsyncIn & ~vsPrev_reg;
  wire vsTrail = ~vsyncIn & vsPrev_reg;
  wire intTick = (divCnt_reg == 8'((`REF_INT_DIV) - 1));
  wire extTick = externalReferenceInput & ~extPrev_reg;
  wire refTick = ctrl_reg[`BIT_EXT_REF] ? extTick : intTick;
  wire [7:0] divCnt_next = intTick ? 8'h00 : divCnt_reg + 8'h01;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      hsPrev_reg <= 1'b0;
      vsPrev_reg <= 1'b0;
      extPrev_reg <= 1'b0;
      divCnt_reg <= 8'h00;
    end
    else
    begin
      hsPrev_reg <= hsyncIn;
      vsPrev_reg <= vsyncIn;
      extPrev_reg <= externalReferenceInput;
      divCnt_reg <= divCnt_next;
    end
  end

  // ****************************************
  // pseudo-sync masking window
  // ****************************************
  logic [8:0] winCnt_reg;
  logic hsFilt_reg;
  logic macSeen_reg;

  wire winActive = (winCnt_reg != 9'h000);
  wire winStart = filterEn & hsLead & ~winActive;
  wire hsAccept = hsLead & (~filterEn | ~winActive);
  wire pseudoHit = filterEn & hsLead & winActive;
  wire [8:0] winCnt_next =
    ~filterEn ? 9'h000 :
    winStart ? {maskWidth_reg, 1'b0} :
    (winActive & refTick) ? winCnt_reg - 9'h001 : winCnt_reg;
  wire hsFilt_next = filterEn ? (winStart | winActive) : hsyncIn;
  wire hsyncOut_next = hsBypass ? hsyncIn ^ pass_reg[`BIT_HORIZONTAL_OUTPUT_INVERT] : hsFilt_next;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      winCnt_reg <= 9'h000;
      hsFilt_reg <= 1'b0;
      hsyncOut <= 1'b0;
    end
    else
    begin
      winCnt_reg <= winCnt_next;
      hsFilt_reg <= hsFilt_next;
      hsyncOut <= hsyncOut_next;
    end
  end

  assign hsyncFiltered = hsFilt_reg;

  // ****************************************
  // vertical to horizontal alignment
  // ****************************************
  sync_measure_pkg::align_e alState_reg;
  sync_measure_pkg::align_e alState_next;
  logic [PIX_W-1:0] pixCnt_reg;
  logic [PIX_W-1:0] lineLen_reg;
  logic [PIX_W-1:0] alCnt_reg;
  logic [PIX_W-1:0] alTarget_reg;
  logic pendLevel_reg;
  logic pendField_reg;
  logic vsAligned_reg;

  wire [PIX_W-1:0] offExt = {{(PIX_W-8){alignOffset_reg[7]}}, alignOffset_reg};
  // an advance fires the stated count before the following horizontal edge
  wire [PIX_W-1:0] alTarget_next = alignOffset_reg[7] ? lineLen_reg + offExt : offExt;
  wire vsEvent = vsLead | vsTrail;
  wire fieldPos = (pixCnt_reg > (lineLen_reg >> 1));
  wire fire = (alState_reg == sync_measure_pkg::AL_COUNT) & (alCnt_reg == alTarget_reg);
  wire [PIX_W-1:0] pixCnt_next = hsAccept ? '0 : pixCnt_reg + PIX_W'(pixelStrobe);

  always_comb
  begin
    alState_next = alState_reg;
    case (alState_reg)
      sync_measure_pkg::AL_IDLE:
        if (vsEvent)
          alState_next = sync_measure_pkg::AL_WAIT;
      sync_measure_pkg::AL_WAIT:
        if (hsAccept)
          alState_next = sync_measure_pkg::AL_COUNT;
      sync_measure_pkg::AL_COUNT:
        if (fire)
          alState_next = vsEvent ? sync_measure_pkg::AL_WAIT : sync_measure_pkg::AL_IDLE;
      default:
        alState_next = sync_measure_pkg::AL_IDLE;
    endcase
  end

  wire vsProc = anyBypass ? vsyncIn : vsAligned_reg;
  wire vsyncOut_next = vsBypass ? vsyncIn ^ pass_reg[`BIT_VERTICAL_OUTPUT_INVERT] : vsProc;
  wire fieldOut_next =
    (anyBypass & vsLead) ? fieldPos :
    (~anyBypass & fire & pendLevel_reg) ? pendField_reg : fieldOut;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      alState_reg <= sync_measure_pkg::AL_IDLE;
      pixCnt_reg <= '0;
      lineLen_reg <= '0;
      alCnt_reg <= '0;
      alTarget_reg <= '0;
      pendLevel_reg <= 1'b0;
      pendField_reg <= 1'b0;
      vsAligned_reg <= 1'b0;
      vsyncOut <= 1'b0;
      fieldOut <= 1'b0;
    end
    else
    begin
      alState_reg <= alState_next;
      pixCnt_reg <= pixCnt_next;
      if (hsAccept)
        lineLen_reg <= pixCnt_reg;
      if (vsEvent)
        pendLevel_reg <= vsyncIn;
      if (vsLead)
        pendField_reg <= fieldPos;
      if (alState_reg == sync_measure_pkg::AL_WAIT && hsAccept)
      begin
        alCnt_reg <= '0;
        alTarget_reg <= alTarget_next;
      end
      else if (pixelStrobe)
        alCnt_reg <= alCnt_reg + PIX_W'(1);
      if (fire)
        vsAligned_reg <= pendLevel_reg;
      vsyncOut <= vsyncOut_next;
      fieldOut <= fieldOut_next;
    end
  end

  // ****************************************
  // measurement counters
  // ****************************************
  // no lock input exists: counting never waits on the pixel clock loop
  logic [11:0] refCnt_reg;
  logic [11:0] cplMax_reg;
  logic [7:0] hswCnt_reg;
  logic [7:0] hswLast_reg;
  logic [11:0] lineCnt_reg;
  logic [11:0] prevLines_reg;
  logic [4:0] vswCnt_reg;
  logic [4:0] vswLast_reg;

  wire [11:0] refInc = refCnt_reg + 12'(refTick & ~&refCnt_reg);
  wire [11:0] cplMax_next =
    vsLead ? (hsAccept ? refCnt_reg : 12'h000) :
    (hsAccept & (refCnt_reg > cplMax_reg)) ? refCnt_reg : cplMax_reg;
  wire [7:0] hswCnt_next =
    hsLead ? 8'h00 :
    (hsyncIn & refTick & ~&hswCnt_reg) ? hswCnt_reg + 8'h01 : hswCnt_reg;
  wire [11:0] lineCnt_next =
    vsLead ? 12'h000 : lineCnt_reg + 12'(hsAccept & ~&lineCnt_reg);
  wire [4:0] vswCnt_next =
    vsLead ? 5'h00 : vswCnt_reg + 5'(vsyncIn & hsAccept & ~&vswCnt_reg);
  wire cplFinal = hsAccept & (refCnt_reg > cplMax_reg);

  always_comb
  begin
    stat_next = stat_reg;
    if (vsLead)
    begin
      // one snapshot per frame keeps the readable set consistent
      stat_next.lines = lineCnt_reg;
      stat_next.clocks = cplFinal ? refCnt_reg : cplMax_reg;
      stat_next.hsWidth = hswLast_reg;
      stat_next.vsWidth = vswLast_reg;
      stat_next.progressive = (lineCnt_reg == prevLines_reg);
      stat_next.pseudoSync = macSeen_reg | pseudoHit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      refCnt_reg <= 12'h000;
      cplMax_reg <= 12'h000;
      hswCnt_reg <= 8'h00;
      hswLast_reg <= 8'h00;
      lineCnt_reg <= 12'h000;
      prevLines_reg <= 12'h000;
      vswCnt_reg <= 5'h00;
      vswLast_reg <= 5'h00;
      macSeen_reg <= 1'b0;
      stat_reg <= '0;
    end
    else
    begin
      refCnt_reg <= hsAccept ? 12'h000 : refInc;
      cplMax_reg <= cplMax_next;
      hswCnt_reg <= hswCnt_next;
      if (hsTrail)
        hswLast_reg <= hswCnt_reg;
      lineCnt_reg <= lineCnt_next;
      if (vsLead)
        prevLines_reg <= lineCnt_reg;
      vswCnt_reg <= vswCnt_next;
      if (vsTrail)
        vswLast_reg <= vswCnt_reg;
      // a hit in the snapshot cycle starts the next frame's flag
      macSeen_reg <= vsLead ? pseudoHit : (macSeen_reg | pseudoHit);
      stat_reg <= stat_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence sAlignArm;
    alState_reg == sync_measure_pkg::AL_WAIT && hsAccept;
  endsequence

  a_window_open: assert property (winStart |=> winCnt_reg == {$past(maskWidth_reg), 1'b0})
    else $error("mask window not loaded");
  a_window_off: assert property (!filterEn |=> !winActive && !pseudoHit)
    else $error("mask window active while filter off");
  a_align_arm: assert property (sAlignArm |=> alCnt_reg == 0)
    else $error("alignment count not started");
  a_align_fire: assert property (fire && !anyBypass ##1 1 |=> vsyncOut == $past(pendLevel_reg, 2))
    else $error("aligned vertical edge wrong");
  a_field_shift: assert property (!anyBypass && fire && pendLevel_reg |=> fieldOut == $past(pendField_reg))
    else $error("field not moved with vertical sync");
  a_hs_pass: assert property (hsBypass |=> hsyncOut == ($past(hsyncIn) ^ $past(pass_reg[`BIT_HORIZONTAL_OUTPUT_INVERT])))
    else $error("horizontal passthrough wrong");
  a_vs_pass: assert property (vsBypass |=> vsyncOut == ($past(vsyncIn) ^ $past(pass_reg[`BIT_VERTICAL_OUTPUT_INVERT])))
    else $error("vertical passthrough wrong");
  a_stat_frame: assert property (vsLead |=> stat_reg.lines == $past(lineCnt_reg) && stat_reg.hsWidth == $past(hswLast_reg))
    else $error("status snapshot wrong");
  a_stat_hold: assert property (!vsLead |=> $stable(stat_reg))
    else $error("status changed outside frame edge");
  a_clk_max: assert property (vsLead |=> stat_reg.clocks >= $past(cplMax_reg))
    else $error("clocks per line below frame maximum");
  a_vs_width: assert property (vsTrail |=> vswLast_reg == $past(vswCnt_reg))
    else $error("vertical width not latched");
  a_ref_ext: assert property (ctrl_reg[`BIT_EXT_REF] && extTick |-> refTick ##1 !refTick)
    else $error("external reference tick lost");
  a_scan_type: assert property (vsLead && lineCnt_reg != prevLines_reg |=> !stat_reg.progressive)
    else $error("scan type wrong");
  a_pseudo_flag: assert property (vsLead && pseudoHit |=> stat_reg.pseudoSync)
    else $error("pseudo-sync flag lost");

endmodule

// [sync_source_model.sv]
`timescale 1ns/1ps
module sync_source_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pseudoOn,
  input wire logic extraLine,
  input wire logic vsLate,
  output logic hsyncIn,
  output logic vsyncIn,
  output logic pixelStrobe,
  output logic externalReferenceInput
);
  // ********************************************
  // 240 clocks a line, 8 lines (9 on odd frames when interlaced)
  // ********************************************
  logic [7:0] pix;
  logic [3:0] line;
  logic [1:0] refDiv;
  logic odd, vs, refLvl;
  wire logic [7:0] vsAt = vsLate ? 8'hB4 : 8'h3C;
  wire logic [3:0] lastLine = (extraLine & odd) ? 4'h8 : 4'h7;
  // pseudo pulse sits 60 clocks after the line start
  assign hsyncIn = pix < 8'h18 || (pseudoOn && pix >= 8'h3C && pix < 8'h48);
  assign vsyncIn = vs;
  assign pixelStrobe = pix[0];
  assign externalReferenceInput = refLvl;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pix <= 8'h00;
      line <= 4'h0;
      odd <= 1'b0;
      vs <= 1'b0;
      refDiv <= 2'h0;
      refLvl <= 1'b0;
    end
    else
    begin
      pix <= (pix == 8'hEF) ? 8'h00 : pix + 8'h01;
      if (pix == 8'hEF)
        line <= (line == lastLine) ? 4'h0 : line + 4'h1;
      if (pix == 8'hEF && line == lastLine)
        odd <= ~odd;
      if (pix == vsAt && line == 4'h0)
        vs <= 1'b1;
      if (pix == vsAt && line == 4'h2)
        vs <= 1'b0;
      // reference rises every 6 clocks, about 20.8 MHz
      refDiv <= (refDiv == 2'h2) ? 2'h0 : refDiv + 2'h1;
      if (refDiv == 2'h2)
        refLvl <= ~refLvl;
    end
  end
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`include "sync_measure_params.svh"
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pseudoOn = 1'b0;
  logic extraLine = 1'b0;
  logic vsLate = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, hsyncIn, vsyncIn, pixelStrobe, externalReferenceInput;
  logic hsyncOut, vsyncOut, fieldOut, hsyncFiltered;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  sync_measure_and_align dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hsyncIn(hsyncIn), .vsyncIn(vsyncIn), .pixelStrobe(pixelStrobe),
    .externalReferenceInput(externalReferenceInput), .hsyncOut(hsyncOut),
    .vsyncOut(vsyncOut), .fieldOut(fieldOut), .hsyncFiltered(hsyncFiltered));
  sync_source_model src_u (.clk(clk), .rstn(rstn), .pseudoOn(pseudoOn),
    .extraLine(extraLine), .vsLate(vsLate), .hsyncIn(hsyncIn), .vsyncIn(vsyncIn),
    .pixelStrobe(pixelStrobe), .externalReferenceInput(externalReferenceInput));
  // ********************************************
  // shared tasks
  // ********************************************
  task automatic give_verdict;
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 20);
    if (n >= 20)
    begin
      mismatches++;
      $display("BAD pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, {24'h0, exp}, rd);
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge vsyncIn);
  endtask
  task automatic win_len(output int len);
    len = 0;
    @(posedge hsyncIn);
    @(posedge hsyncFiltered);
    @(negedge clk);
    while (hsyncFiltered === 1'b1 && len < 500)
    begin
      len++;
      @(negedge clk);
    end
  endtask
  task automatic vs_delay(output int d, output logic f);
    d = 0;
    @(posedge vsyncIn);
    while (vsyncOut !== 1'b1 && d < 700)
    begin
      @(negedge clk);
      d++;
    end
    f = fieldOut;
  endtask
  // ********************************************
  // scenarios
  // ********************************************
  task automatic t_regs;
    rdchk("width reset", `IDX_MASK_WIDTH, 8'h03);
    rdchk("align reset", `IDX_ALIGN, 8'h10);
    rdchk("pass reset", `IDX_PASS, 8'h00);
    apb(1'b1, `IDX_MASK_WIDTH, 8'hA5);
    rdchk("width rw", `IDX_MASK_WIDTH, 8'hA5);
    apb(1'b1, `IDX_PASS, 8'hFF);
    rdchk("pass rw", `IDX_PASS, 8'h0F);
    apb(1'b1, `IDX_PASS, 8'h00);
    apb(1'b1, 8'h3D, 8'h55);
    chk("unmapped err", 32'h1, {31'h0, err});
    rdchk("unmapped rd", 8'h3D, 8'h00);
  endtask
  task automatic t_measure;
    apb(1'b1, `IDX_CTRL, 8'h02);
    frames(3);
    rdchk("lines lo", `IDX_LINES_LO, 8'h08);
    rdchk("lines hi", `IDX_LINES_HI, 8'h20);
    rdchk("clocks lo", `IDX_CLOCKS_LO, 8'h28);
    rdchk("clocks hi", `IDX_CLOCKS_HI, 8'h00);
    rdchk("hs width", `IDX_HS_WIDTH, 8'h04);
    rdchk("vs width", `IDX_VS_WIDTH, 8'h02);
    apb(1'b1, `IDX_CTRL, 8'h00);
    frames(3);
    apb(1'b0, `IDX_CLOCKS_LO, 8'h00);
    chk("internal clocks", 32'h1, {31'h0, rd >= 32'd12 && rd <= 32'd13});
    extraLine <= 1'b1;
    frames(3);
    rdchk("interlaced hi", `IDX_LINES_HI, 8'h00);
    extraLine <= 1'b0;
  endtask
  task automatic t_pseudo;
    int len;
    apb(1'b1, `IDX_CTRL, 8'h03);
    apb(1'b1, `IDX_MASK_WIDTH, 8'h08);
    pseudoOn <= 1'b1;
    frames(3);
    rdchk("masked lines", `IDX_LINES_LO, 8'h08);
    rdchk("pseudo flag", `IDX_LINES_HI, 8'h60);
    win_len(len);
    chk("window", 32'h1, {31'h0, len >= 90 && len <= 100});
    apb(1'b1, `IDX_CTRL, 8'h02);
    frames(3);
    rdchk("unmasked lines", `IDX_LINES_LO, 8'h10);
    rdchk("no flag", `IDX_LINES_HI, 8'h20);
    pseudoOn <= 1'b0;
    frames(1);
    win_len(len);
    chk("no window", 32'd24, 32'(len));
  endtask
  task automatic t_bypass;
    logic [3:0] c;
    logic h, v;
    int e = 0;
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      apb(1'b1, `IDX_PASS, {4'h0, c});
      repeat (2) @(posedge clk);
      repeat (1920)
      begin
        @(posedge clk);
        h = hsyncIn;
        v = vsyncIn;
        #1;
        if (c[0] && hsyncOut !== (h ^ c[2]))
          e++;
        if ((c[0] | c[1]) && vsyncOut !== (v ^ (c[1] & c[3])))
          e++;
      end
    end
    chk("bypass errors", 32'h0, 32'(e));
    apb(1'b1, `IDX_PASS, 8'h00);
  endtask
  task automatic t_align;
    int d4, d10, dn, dl;
    logic f0, f1;
    apb(1'b1, `IDX_ALIGN, 8'h04);
    frames(1);
    vs_delay(d4, f0);
    apb(1'b1, `IDX_ALIGN, 8'h10);
    frames(1);
    vs_delay(d10, f1);
    chk("delay step", 32'd24, 32'(d10 - d4));
    apb(1'b1, `IDX_ALIGN, 8'hFC);
    frames(1);
    vs_delay(dn, f1);
    chk("advance", 32'd224, 32'(dn - d4));
    vsLate <= 1'b1;
    apb(1'b1, `IDX_ALIGN, 8'h04);
    frames(2);
    vs_delay(dl, f1);
    chk("late delay", 32'd120, 32'(d4 - dl));
    chk("field early", 32'h0, {31'h0, f0});
    chk("field late", 32'h1, {31'h0, f1});
    vsLate <= 1'b0;
  endtask
  // ********************************************
  // main sequence and timeout
  // ********************************************
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_measure();
    t_pseudo();
    t_bypass();
    t_align();
    give_verdict();
  end
endmodule
